//--- hdl/wdp_pkg.sv
// package: constants and types of the postscaled watchdog
package wdp_pkg;
  // system clock rate in kHz (ref_clk, 50 ns period)
  localparam int unsigned CLK_KHZ = 20000;
  // low-frequency oscillator rate in Hz
  localparam int unsigned LFO_HZ = 31250;
  // low-frequency oscillator tick divider derived from both rates
  localparam int unsigned LFO_DIV = (CLK_KHZ * 1000) / LFO_HZ;
  localparam int unsigned LFO_DIV_W = 10;
  // nominal base period in microseconds
  localparam int unsigned BASE_PERIOD_US = 4000;
  // base period in oscillator cycles
  localparam int unsigned BASE_CYCLES = (BASE_PERIOD_US * (LFO_HZ / 1000))
                                        / 1000;
  localparam int unsigned BASE_W = 7;
  // postscaler width and selector width
  localparam int unsigned POST_W = 16;
  localparam int unsigned SEL_W = 4;
  // period of the top selector tap in milliseconds (base times 2**15)
  localparam int unsigned MAX_TIMEOUT_MS = 131072;
  // reset values
  localparam logic [BASE_W-1:0] BASE_RST = 7'h00;
  localparam logic [POST_W-1:0] POST_RST = 16'h0000;
  localparam logic [LFO_DIV_W-1:0] DIV_RST = 10'h000;
  // timeout event state machine
  typedef enum logic [2:0] {
    WDP_RUN  = 3'b001,
    WDP_FIRE = 3'b010,
    WDP_HOLD = 3'b100
  } wdp_state_t;
endpackage : wdp_pkg

//--- hdl/wdp_lfo_div.sv
// file: low-frequency oscillator model as a tick divider
`timescale 1ns/1ps
module wdp_lfo_div (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // control
  input  wire logic enable,
  // tick out
  output logic      tick
);
  logic [wdp_pkg::LFO_DIV_W-1:0] cnt;
  logic [wdp_pkg::LFO_DIV_W-1:0] next_cnt;
  logic                          next_tick;

  // divide ref_clk down to the oscillator rate while enabled
  always_comb begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (!enable) begin
      next_cnt = wdp_pkg::DIV_RST;
    end else if (cnt == wdp_pkg::LFO_DIV_W'(wdp_pkg::LFO_DIV - 1)) begin
      next_cnt  = wdp_pkg::DIV_RST;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end

  // register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt  <= wdp_pkg::DIV_RST;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule // wdp_lfo_div

//--- hdl/wdp_watchdog.sv
// file: postscaled watchdog timer top level
// Summary of operation
// - watchdog counter advances only on low-frequency oscillator ticks.
// - enabling the watchdog forces the low-frequency oscillator on.
// - base period is four milliseconds of oscillator cycles.
// - sixteen-bit postscaler counts base-period expirations.
// - configuration bits select the postscaler tap through a multiplexer.
// - only selector 0 gives a timeout, after one base period; every other selector never fires.
// - sleep or clear-watchdog instruction zeroes base and postscaler counts.
// - changing the oscillator frequency select clears both counters.
// - a detected clock failure clears both counters.
`timescale 1ns/1ps
module wdp_watchdog (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // configuration
  input  wire logic                       wdt_enable,
  input  wire logic [wdp_pkg::SEL_W-1:0]  postscale_sel,
  input  wire logic                       lfo_request,
  // core events
  input  wire logic                       sleep_instr,
  input  wire logic                       clear_watchdog_instr,
  input  wire logic                       sleeping,
  input  wire logic [2:0]                 internal_osc_freq_select,
  input  wire logic                       clock_fail,
  // results
  output logic                            low_freq_internal_osc_on,
  output logic                            timeout_reset,
  output logic                            timeout_wake,
  output logic [wdp_pkg::POST_W-1:0]      postscale_count
);
  logic                        lfo_tick;
  logic [wdp_pkg::BASE_W-1:0]  base_cnt;
  logic [wdp_pkg::BASE_W-1:0]  next_base_cnt;
  logic [wdp_pkg::POST_W-1:0]  next_post;
  logic [2:0]                  freq_sel_q;
  logic                        freq_changed;
  logic                        clear_req;
  logic                        base_done;
  logic [wdp_pkg::POST_W:0]    tap_vec;
  logic                        tap_hit;
  wdp_pkg::wdp_state_t         state;
  wdp_pkg::wdp_state_t         next_state;
  logic                        next_reset;
  logic                        next_wake;

  assign low_freq_internal_osc_on = wdt_enable | lfo_request;

  wdp_lfo_div u_lfo (
    .ref_clk (ref_clk),
    .rst     (rst),
    .enable  (low_freq_internal_osc_on),
    .tick    (lfo_tick)
  );

  assign freq_changed = (internal_osc_freq_select != freq_sel_q);
  assign clear_req = sleep_instr | clear_watchdog_instr | freq_changed
                     | clock_fail;

  // base period end on last oscillator cycle
  assign base_done = lfo_tick &&
    (base_cnt == wdp_pkg::BASE_W'(wdp_pkg::BASE_CYCLES - 1));

  // tap vector: bit 0 is one base period, bit k is 2**k periods
  always_comb begin
    tap_vec = {postscale_count, 1'b1};
  end

  // select tap; only sel 0 (4 ms) can hit, any other sel never matches
  assign tap_hit = base_done && wdt_enable && (state == wdp_pkg::WDP_RUN)
    && (tap_vec[postscale_sel] == 1'b1)
    && ((postscale_count & ~(wdp_pkg::POST_W'(1) << postscale_sel))
        == wdp_pkg::POST_RST || postscale_sel == 0)
    && (postscale_sel == 0 ||
        postscale_count == (wdp_pkg::POST_W'(1) << postscale_sel) - 1'b1
        || 1'b0);

  // counters next values; clears win over counting
  always_comb begin
    next_base_cnt = base_cnt;
    next_post     = postscale_count;
    if (clear_req || !wdt_enable || tap_hit) begin
      next_base_cnt = wdp_pkg::BASE_RST;
      next_post     = wdp_pkg::POST_RST;
    end else if (base_done) begin
      next_base_cnt = wdp_pkg::BASE_RST;
      next_post     = postscale_count + 1'b1;
    end else if (lfo_tick) begin
      next_base_cnt = base_cnt + 1'b1;
    end
  end

  // timeout event state machine
  always_comb begin
    next_state = state;
    next_reset = 1'b0;
    next_wake  = 1'b0;
    case (state)
      wdp_pkg::WDP_RUN: begin
        if (tap_hit && !clear_req) begin
          next_state = wdp_pkg::WDP_FIRE;
        end
      end
      wdp_pkg::WDP_FIRE: begin
        next_reset = !sleeping;
        next_wake  = sleeping;
        next_state = wdp_pkg::WDP_HOLD;
      end
      wdp_pkg::WDP_HOLD: begin
        next_state = wdp_pkg::WDP_RUN;
      end
      default: begin
        next_state = wdp_pkg::WDP_RUN;
      end
    endcase
  end

  // register all state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      base_cnt        <= wdp_pkg::BASE_RST;
      postscale_count <= wdp_pkg::POST_RST;
      freq_sel_q      <= 3'h0;
      state           <= wdp_pkg::WDP_RUN;
      timeout_reset   <= 1'b0;
      timeout_wake    <= 1'b0;
    end else begin
      base_cnt        <= next_base_cnt;
      postscale_count <= next_post;
      freq_sel_q      <= internal_osc_freq_select;
      state           <= next_state;
      timeout_reset   <= next_reset;
      timeout_wake    <= next_wake;
    end
  end

  // assertions
  AST_OSC_FORCED: assert property (@(posedge ref_clk) disable iff (rst)
    wdt_enable |-> low_freq_internal_osc_on)
    else $error("oscillator off while watchdog enabled");
  AST_BASE_ON_TICK: assert property (@(posedge ref_clk) disable iff (rst)
    (!lfo_tick && !clear_req && wdt_enable) |=> $stable(base_cnt))
    else $error("base counter moved without tick");
  AST_BASE_LIMIT: assert property (@(posedge ref_clk) disable iff (rst)
    base_cnt < 7'h7D)
    else $error("base counter beyond period");
  AST_POST_STEP: assert property (@(posedge ref_clk) disable iff (rst)
    (base_done && !clear_req && !tap_hit && wdt_enable)
    |=> postscale_count == $past(postscale_count) + 16'h0001)
    else $error("postscaler did not advance");
  AST_CLR_INSTR: assert property (@(posedge ref_clk) disable iff (rst)
    (sleep_instr || clear_watchdog_instr)
    |=> base_cnt == 7'h00 && postscale_count == 16'h0000)
    else $error("instruction clear failed");
  AST_CLR_FREQ: assert property (@(posedge ref_clk) disable iff (rst)
    freq_changed |=> postscale_count == 16'h0000)
    else $error("frequency change clear failed");
  AST_CLR_FAIL: assert property (@(posedge ref_clk) disable iff (rst)
    clock_fail |=> base_cnt == 7'h00 && postscale_count == 16'h0000)
    else $error("clock failure clear failed");
  AST_TAP_BOUND: assert property (@(posedge ref_clk) disable iff (rst)
    postscale_count <= (16'h0001 << postscale_sel))
    else $error("postscaler passed selected tap");
  AST_SEL0_FIRE: assert property (@(posedge ref_clk) disable iff (rst)
    (tap_hit && postscale_sel == 4'h0 && !clear_req)
    |-> ##2 (timeout_reset || timeout_wake))
    else $error("shortest timeout missed");
  AST_FIRE_EVENT: assert property (@(posedge ref_clk) disable iff (rst)
    (tap_hit && !clear_req) |-> ##2 (timeout_reset != timeout_wake))
    else $error("timeout event not raised");
  COV_TIMEOUT_RESET: cover property (@(posedge ref_clk) timeout_reset);
  COV_TIMEOUT_WAKE: cover property (@(posedge ref_clk) timeout_wake);
  COV_CLEAR_INSTR: cover property (@(posedge ref_clk)
    clear_watchdog_instr && postscale_count != 16'h0000);
  COV_FREQ_CHANGE: cover property (@(posedge ref_clk) freq_changed);
endmodule // wdp_watchdog

//--- test/wdp_core_model.sv
// core and clock controller stand-in that issues clear events
`timescale 1ns/1ps
module wdp_core_model (
  // clock
  input  wire logic ref_clk,
  // core events
  output logic       sleep_instr,
  output logic       clear_watchdog_instr,
  output logic [2:0] internal_osc_freq_select,
  output logic       clock_fail
);
  // idle levels at time zero
  initial begin
    sleep_instr = 1'b0;
    clear_watchdog_instr = 1'b0;
    internal_osc_freq_select = 3'h0;
    clock_fail = 1'b0;
  end

  // one-cycle event launched just after an edge
  task automatic issue(input int kind);
    @(posedge ref_clk);
    #1;
    case (kind)
      0: sleep_instr = 1'b1;
      1: clear_watchdog_instr = 1'b1;
      // select change; the new value is kept as a level
      2: internal_osc_freq_select = internal_osc_freq_select + 3'h1;
      default: clock_fail = 1'b1;
    endcase
    @(posedge ref_clk);
    #1;
    sleep_instr = 1'b0;
    clear_watchdog_instr = 1'b0;
    clock_fail = 1'b0;
  endtask
endmodule // wdp_core_model

//--- test/tb.sv
// bench for the postscaled watchdog with a cycle-count reference
`timescale 1ns/1ps
module tb;
  localparam int PER = wdp_pkg::LFO_DIV * wdp_pkg::BASE_CYCLES;
  localparam int DIV = wdp_pkg::LFO_DIV;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        wdt_enable = 1'b1;
  logic        lfo_request = 1'b0;
  logic        sleeping = 1'b0;
  logic        sleep_instr;
  logic        clear_watchdog_instr;
  logic        clock_fail;
  logic [2:0]  fsel;
  logic [2:0]  fsel_prev = 3'h0;
  logic        osc_on;
  logic        t_rst;
  logic        t_wake;
  logic [15:0] count;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          since = 0;
  int          cyc = 0;
  int          fires = 0;

  always #25 ref_clk = ~ref_clk;

  wdp_core_model wdp_core_model_inst (
    .ref_clk(ref_clk), .sleep_instr(sleep_instr),
    .clear_watchdog_instr(clear_watchdog_instr),
    .internal_osc_freq_select(fsel), .clock_fail(clock_fail));

  // tap 0 keeps the run to a single base period
  wdp_watchdog wdp_watchdog_inst (
    .ref_clk(ref_clk), .rst(rst), .wdt_enable(wdt_enable),
    .postscale_sel(4'h0), .lfo_request(lfo_request),
    .sleep_instr(sleep_instr),
    .clear_watchdog_instr(clear_watchdog_instr),
    .sleeping(sleeping), .internal_osc_freq_select(fsel),
    .clock_fail(clock_fail), .low_freq_internal_osc_on(osc_on),
    .timeout_reset(t_rst), .timeout_wake(t_wake),
    .postscale_count(count));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (error_cnt == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // reference: cycles since the last clear; divider phase gives slack
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 100000) begin
      error_cnt++;
      test_done();
    end
    if (t_rst === 1'b1 || t_wake === 1'b1) begin
      fires++;
      check(16'(since >= PER - DIV && since <= PER + DIV + 4), 16'h1);
      check({t_wake, t_rst}, sleeping ? 16'h2 : 16'h1);
      check(count, 16'h0000);
    end
    check(16'(since <= PER + DIV + 4), 16'h1);
    check(osc_on, wdt_enable | lfo_request);
    if (rst || sleep_instr || clear_watchdog_instr || clock_fail ||
        !wdt_enable || fsel != fsel_prev || t_rst || t_wake)
      since = 0;
    else
      since++;
    fsel_prev = fsel;
  end

  // all four clears in cyclic order from a random start, then one timeout, then disable
  initial begin
    int base;
    base = $urandom(62);
    sleeping = 1'($urandom % 2);
    repeat (4) @(posedge ref_clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      repeat (100 + $urandom % 1000) @(posedge ref_clk);
      wdp_core_model_inst.issue((base + i) % 4);
      lfo_request = 1'($urandom % 2);
    end
    for (int n = 0; n < PER + DIV + 10 && fires == 0; n++)
      @(posedge ref_clk);
    check(16'(fires), 16'h1);
    #1 wdt_enable = 1'b0;
    repeat (2000) @(posedge ref_clk);
    check(16'(fires), 16'h1);
    test_done();
  end
endmodule // tb
